// File: logic/spg_pkg.sv
package spg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_JERK     = 8'h04;
  localparam logic [7:0] OFS_SLOWRATE = 8'h08;
  localparam logic [7:0] OFS_ACC_LIM  = 8'h0c;
  localparam logic [7:0] OFS_DEC_LIM  = 8'h10;
  localparam logic [7:0] OFS_START_SP = 8'h14;
  localparam logic [7:0] OFS_DRIVE_SP = 8'h18;
  localparam logic [7:0] OFS_PULSES   = 8'h1c;
  localparam logic [7:0] OFS_SLOW_PT  = 8'h20;
  localparam logic [7:0] OFS_COMMAND  = 8'h24;
  localparam logic [7:0] OFS_STATUS   = 8'h28;
  localparam logic [7:0] OFS_SPEED    = 8'h2c;
  localparam logic [7:0] OFS_OUT_CNT  = 8'h30;
  // Mode word bit positions
  localparam int MB_MANUAL   = 0;
  localparam int MB_SEP_RATE = 1;
  localparam int MB_CURVED   = 2;
  // Command codes, low nibble of the command word; bit 4 is direction
  localparam logic [3:0] CMD_FIXED    = 4'h1;
  localparam logic [3:0] CMD_CONT     = 4'h2;
  localparam logic [3:0] CMD_SLOWSTOP = 4'h3;
  localparam logic [3:0] CMD_HALT     = 4'h4;
  localparam int CMD_DIR_BIT = 4;
  // Reset values
  localparam logic [15:0] RST_RATE  = 16'h0001;
  localparam logic [15:0] RST_LIMIT = 16'd8000;
  localparam logic [15:0] RST_SPEED = 16'h0001;
  // Speed is 16.8 fixed point, in pulses per second
  localparam int FRAC_W = 8;
  localparam int SPD_W  = 24;
  // Profile update period
  localparam int CLK_PERIOD_NS = 20;
  localparam int PROF_TICK_NS  = 10000;
  localparam int PROF_TICK_CYC = PROF_TICK_NS / CLK_PERIOD_NS;
  // Phase step per pps: 2^32 / 50 MHz, truncated
  localparam logic [7:0] NCO_SCALE = 8'd85;
  typedef enum logic [2:0] {
    SPG_IDLE, SPG_ACC_UP, SPG_ACC_DOWN, SPG_CONST, SPG_DEC_UP, SPG_DEC_DOWN
  } spg_state_t;
endpackage

// File: logic/spg_pulse_if.sv
`timescale 1ns/10ps
interface spg_pulse_if;
  logic        run;
  logic [15:0] speed;
  logic        pulse;
  modport ctl (output run, output speed, input pulse);
  modport gen (input run, input speed, output pulse);
endinterface // spg_pulse_if

// File: logic/spg_pulse_gen.sv
`timescale 1ns/10ps
module spg_pulse_gen (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Speed in, pulse out
  spg_pulse_if.gen  pif
);
  import spg_pkg::*;

  logic [32:0] phase_nxt;
  logic [31:0] phase_r;
  logic        pulse_r;
  logic [23:0] step;

  // Phase carry marks one pulse; truncated scale makes the average rate about 1% below speed
  assign step      = 24'(pif.speed) * 24'(NCO_SCALE);
  assign phase_nxt = {1'b0, phase_r} + {9'h000, step};
  assign pif.pulse = pulse_r;

  always_ff @(posedge sys_clk) begin
    if (reset || !pif.run) begin
      phase_r <= 32'h0000_0000;
      pulse_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt[31:0];
      pulse_r <= phase_nxt[32];
    end
  end
endmodule // spg_pulse_gen

// File: logic/spg_scurve_top.sv
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - Acceleration rises linearly at jerk rate
// - Ease acceleration when remaining gap reaches rise gain
// - Hold speed at target or zero acceleration
// - Auto decel when remaining pulses at or below acceleration pulses
// - Continuous speed change uses same S ramp
// - Rising acceleration capped at acceleration limit
// - Stop acceleration rise past one twelfth
// - Stop during acceleration: zero acceleration first
// - Low start speed may creep or end early
// - Non-symmetrical mode decelerates with separate rate
// - Non-symmetrical fixed drive uses manual slowdown point
// - No one-twelfth rule in non-symmetrical mode
module spg_scurve_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Stop pins
  input  wire logic [3:0]  external_stop_inputs,
  // Motor driver
  output logic             drive_pulse,
  output logic             drive_dir,
  output logic             drive_busy
);
  import spg_pkg::*;

  spg_pulse_if pif ();

  logic [2:0]       axis_mode_word_r;
  logic [15:0]      jerk_r, slow_rate_r, acc_lim_r, dec_lim_r;
  logic [15:0]      start_speed_r, drive_speed_r;
  logic [31:0]      pulses_r, manual_slowdown_point_r;
  logic [31:0]      out_cnt_r, acc_pulses_r;
  logic [3:0]       stop_s1_r, stop_s2_r;
  logic [8:0]       tick_cnt_r;
  logic             tick;
  logic             access, wr_en, cmd_wr, addr_ok;
  logic [3:0]       cmd;
  logic             fixed_r, stopping_r, stop_req;
  spg_state_t       state_r;
  logic [SPD_W-1:0] speed_r, accel_r, gain_r, floor_r;
  logic [SPD_W-1:0] tgt, rate_up, rate_dn, lim_up, lim_dn, sv_fp;
  logic             manual_slowdown_select, separate_slowdown_rate_enable;
  logic             curved_ramp_select;
  logic             done, auto_slow, tri_hit, remain_le, drive_end;

  function automatic logic [SPD_W-1:0] fp(input logic [15:0] v);
    return {v, {FRAC_W{1'b0}}};
  endfunction

  function automatic logic [SPD_W-1:0] ext(input logic [15:0] v);
    return {{(SPD_W-16){1'b0}}, v};
  endfunction

  function automatic logic [SPD_W-1:0] add_cap(input logic [SPD_W-1:0] a,
                                              input logic [SPD_W-1:0] b,
                                              input logic [SPD_W-1:0] cap);
    logic [SPD_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return (s > {1'b0, cap}) ? cap : s[SPD_W-1:0];
  endfunction

  function automatic logic [SPD_W-1:0] sub_floor(input logic [SPD_W-1:0] a,
                                                input logic [SPD_W-1:0] b,
                                                input logic [SPD_W-1:0] fl);
    logic [SPD_W-1:0] d;
    d = (a > b) ? a - b : '0;
    return (d < fl) ? fl : d;
  endfunction

  // APB decode; one wait state so every answer comes from a flop
  assign access  = psel && penable;
  assign wr_en   = access && pwrite && pready;
  assign cmd_wr  = wr_en && (paddr == OFS_COMMAND);
  assign cmd     = pwdata[3:0];
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= OFS_OUT_CNT);

  assign manual_slowdown_select        = axis_mode_word_r[MB_MANUAL];
  assign separate_slowdown_rate_enable = axis_mode_word_r[MB_SEP_RATE];
  assign curved_ramp_select            = axis_mode_word_r[MB_CURVED];

  // Without the curved mode acceleration jumps to its limit, giving a trapezoid
  assign tgt     = fp(drive_speed_r);
  assign sv_fp   = fp(start_speed_r);
  assign lim_up  = ext(acc_lim_r);
  assign lim_dn  = separate_slowdown_rate_enable ? ext(dec_lim_r) : ext(acc_lim_r);
  assign rate_up = curved_ramp_select ? ext(jerk_r) : lim_up;
  assign rate_dn = !curved_ramp_select ? lim_dn :
                   separate_slowdown_rate_enable ? ext(slow_rate_r) : ext(jerk_r);
  assign remain_le = (pulses_r - out_cnt_r) <= acc_pulses_r;
  // Manual point when selected, else mirror the pulses used accelerating
  assign auto_slow = fixed_r && !stopping_r &&
                     (manual_slowdown_select ? out_cnt_r >= manual_slowdown_point_r
                                             : remain_le);
  // Twelve times the accel pulses against the total, symmetric mode only
  assign tri_hit = fixed_r && curved_ramp_select && !manual_slowdown_select &&
                   (({2'b00, acc_pulses_r, 2'b00} + {1'b0, acc_pulses_r, 3'b000})
                    > {4'h0, pulses_r});
  assign done = fixed_r && (out_cnt_r >= pulses_r);
  assign drive_end = (cmd_wr && cmd == CMD_HALT) || (drive_busy && (done ||
                     (stopping_r && speed_r == sv_fp && state_r != SPG_ACC_DOWN && !fixed_r)));
  assign stop_req = (cmd_wr && cmd == CMD_SLOWSTOP) || (|stop_s2_r);

  assign pif.run   = drive_busy && !done;
  assign pif.speed = speed_r[SPD_W-1:FRAC_W];

  spg_pulse_gen u_gen (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pif     (pif)
  );

  // Stop pins cross in through two flops
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stop_s1_r <= 4'h0;
      stop_s2_r <= 4'h0;
    end else begin
      stop_s1_r <= external_stop_inputs;
      stop_s2_r <= stop_s1_r;
    end
  end

  // Profile update period
  always_ff @(posedge sys_clk) begin
    if (reset || tick_cnt_r == 9'(PROF_TICK_CYC - 1)) begin
      tick_cnt_r <= 9'h000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 9'h001;
    end
  end
  assign tick = (tick_cnt_r == 9'(PROF_TICK_CYC - 1));

  // Parameter registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      axis_mode_word_r        <= 3'b000;
      jerk_r                  <= RST_RATE;
      slow_rate_r             <= RST_RATE;
      acc_lim_r               <= RST_LIMIT;
      dec_lim_r               <= RST_LIMIT;
      start_speed_r           <= RST_SPEED;
      drive_speed_r           <= RST_SPEED;
      pulses_r                <= 32'h0000_0000;
      manual_slowdown_point_r <= 32'h0000_0000;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_MODE:     axis_mode_word_r        <= pwdata[2:0];
        OFS_JERK:     jerk_r                  <= pwdata[15:0];
        OFS_SLOWRATE: slow_rate_r             <= pwdata[15:0];
        OFS_ACC_LIM:  acc_lim_r               <= pwdata[15:0];
        OFS_DEC_LIM:  dec_lim_r               <= pwdata[15:0];
        OFS_START_SP: start_speed_r           <= pwdata[15:0];
        OFS_DRIVE_SP: drive_speed_r           <= pwdata[15:0];
        OFS_PULSES:   pulses_r                <= pwdata;
        OFS_SLOW_PT:  manual_slowdown_point_r <= pwdata;
        default: ;
      endcase
    end
  end

  // APB answer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !addr_ok;
      prdata  <= 32'h0000_0000;
      if (access && !pready && !pwrite) begin
        unique case (paddr)
          OFS_JERK:     prdata <= {16'h0000, jerk_r};
          OFS_SLOWRATE: prdata <= {16'h0000, slow_rate_r};
          OFS_ACC_LIM:  prdata <= {16'h0000, acc_lim_r};
          OFS_DEC_LIM:  prdata <= {16'h0000, dec_lim_r};
          OFS_START_SP: prdata <= {16'h0000, start_speed_r};
          OFS_DRIVE_SP: prdata <= {16'h0000, drive_speed_r};
          OFS_PULSES:   prdata <= pulses_r;
          OFS_SLOW_PT:  prdata <= manual_slowdown_point_r;
          OFS_STATUS:   prdata <= {24'h00_0000, fixed_r, stopping_r, drive_dir,
                                   state_r, 1'b0, drive_busy};
          OFS_SPEED:    prdata <= {8'h00, speed_r};
          OFS_OUT_CNT:  prdata <= out_cnt_r;
          default:      prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pulse output and counters
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      drive_pulse  <= 1'b0;
      out_cnt_r    <= 32'h0000_0000;
      acc_pulses_r <= 32'h0000_0000;
    end else if (cmd_wr && (cmd == CMD_FIXED || cmd == CMD_CONT) && !drive_busy) begin
      drive_pulse  <= 1'b0;
      out_cnt_r    <= 32'h0000_0000;
      acc_pulses_r <= 32'h0000_0000;
    end else begin
      drive_pulse <= pif.pulse && !drive_end;
      if (pif.pulse && !drive_end) begin
        out_cnt_r <= out_cnt_r + 32'h0000_0001;
        if ((state_r == SPG_ACC_UP || state_r == SPG_ACC_DOWN) && !stopping_r) begin
          acc_pulses_r <= acc_pulses_r + 32'h0000_0001;
        end
      end
    end
  end

  // Speed profile
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r    <= SPG_IDLE;
      speed_r    <= '0;
      accel_r    <= '0;
      gain_r     <= '0;
      floor_r    <= '0;
      fixed_r    <= 1'b0;
      stopping_r <= 1'b0;
      drive_busy <= 1'b0;
      drive_dir  <= 1'b0;
    end else if (cmd_wr && cmd == CMD_HALT) begin
      state_r    <= SPG_IDLE;
      drive_busy <= 1'b0;
      accel_r    <= '0;
      stopping_r <= 1'b0;
    end else if (!drive_busy) begin
      if (cmd_wr && (cmd == CMD_FIXED || cmd == CMD_CONT)) begin
        state_r    <= SPG_ACC_UP;
        fixed_r    <= (cmd == CMD_FIXED);
        drive_dir  <= pwdata[CMD_DIR_BIT];
        drive_busy <= 1'b1;
        speed_r    <= sv_fp;
        floor_r    <= sv_fp;
        accel_r    <= '0;
        gain_r     <= '0;
        stopping_r <= 1'b0;
      end
    end else if (drive_end) begin
      state_r    <= SPG_IDLE;
      drive_busy <= 1'b0;
      accel_r    <= '0;
      stopping_r <= 1'b0;
    end else begin
      // Stop request: rising acceleration must ease to zero first
      if (stop_req && !stopping_r) begin
        stopping_r <= 1'b1;
        floor_r    <= sv_fp;
        if (state_r == SPG_ACC_UP) begin
          state_r <= SPG_ACC_DOWN;
        end else if (state_r == SPG_CONST) begin
          state_r <= SPG_DEC_UP;
          gain_r  <= '0;
          accel_r <= '0;
        end
      end else if (tick) begin
        unique case (state_r)
          SPG_ACC_UP: begin
            accel_r <= add_cap(accel_r, rate_up, lim_up);
            speed_r <= add_cap(speed_r, accel_r, tgt);
            gain_r  <= add_cap(gain_r, accel_r, '1);
            if (auto_slow) begin
              stopping_r <= 1'b1;
              state_r    <= SPG_ACC_DOWN;
            end else if (tgt - speed_r <= gain_r || speed_r >= tgt || tri_hit) begin
              state_r <= SPG_ACC_DOWN;
            end
          end
          SPG_ACC_DOWN: begin
            accel_r <= sub_floor(accel_r, rate_up, '0);
            speed_r <= add_cap(speed_r, accel_r, tgt);
            if (accel_r == '0 || speed_r >= tgt) begin
              accel_r <= '0;
              gain_r  <= '0;
              state_r <= (stopping_r || auto_slow) ? SPG_DEC_UP : SPG_CONST;
              if (auto_slow) begin
                stopping_r <= 1'b1;
              end
            end
          end
          SPG_CONST: begin
            if (auto_slow) begin
              stopping_r <= 1'b1;
              floor_r    <= sv_fp;
              gain_r     <= '0;
              state_r    <= SPG_DEC_UP;
            end else if (!fixed_r && speed_r < tgt) begin
              gain_r  <= '0;
              state_r <= SPG_ACC_UP;
            end else if (!fixed_r && speed_r > tgt) begin
              gain_r  <= '0;
              floor_r <= (tgt > sv_fp) ? tgt : sv_fp;
              state_r <= SPG_DEC_UP;
            end
          end
          SPG_DEC_UP: begin
            accel_r <= add_cap(accel_r, rate_dn, lim_dn);
            speed_r <= sub_floor(speed_r, accel_r, floor_r);
            gain_r  <= add_cap(gain_r, accel_r, '1);
            if (speed_r - floor_r <= gain_r) begin
              state_r <= SPG_DEC_DOWN;
            end
          end
          SPG_DEC_DOWN: begin
            accel_r <= sub_floor(accel_r, rate_dn, '0);
            speed_r <= sub_floor(speed_r, accel_r, floor_r);
            // Low start speed leaves creep pulses here, or ends early
            if ((accel_r == '0 || speed_r == floor_r) && !stopping_r) begin
              accel_r <= '0;
              state_r <= SPG_CONST;
            end
          end
          default: state_r <= SPG_IDLE;
        endcase
      end
    end
  end
endmodule // spg_scurve_top

// File: tb/spg_motor_model.sv
`timescale 1ns/10ps
module spg_motor_model (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Bench control
  input  wire logic        clr,
  // Drive pins
  input  wire logic        drive_pulse,
  input  wire logic        drive_dir,
  // What the driver saw
  output logic      [15:0] pulse_cnt,
  output logic             last_dir,
  output logic      [31:0] gap_min,
  output logic      [31:0] gap_max
);
  logic [31:0] gap_r;
  logic        have_r;
  // A step input never pushes back, so the model only counts and times steps and keeps the last direction
  always_ff @(posedge sys_clk) begin
    if (reset || clr) begin
      pulse_cnt <= 16'h0;
      last_dir  <= 1'b0;
      gap_r     <= 32'h0;
      have_r    <= 1'b0;
      gap_min   <= 32'hffffffff;
      gap_max   <= 32'h0;
    end else begin
      gap_r <= gap_r + 32'h1;
      if (drive_pulse) begin
        pulse_cnt <= pulse_cnt + 16'h1;
        last_dir  <= drive_dir;
        gap_r     <= 32'h1;
        have_r    <= 1'b1;
        if (have_r && gap_r < gap_min) gap_min <= gap_r;
        if (have_r && gap_r > gap_max) gap_max <= gap_r;
      end
    end
  end
endmodule // spg_motor_model

// File: tb/spg_scurve_top_properties.sv
`timescale 1ns/10ps
module spg_scurve_checker
  import spg_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic [3:0]  external_stop_inputs,
  input wire logic        drive_pulse,
  input wire logic        drive_dir,
  input wire logic        drive_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  ready_wait_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  ready_phase_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("prdata not zero outside read answer");
  mode_wo_a: assert property (pready && !pwrite && paddr == OFS_MODE |-> prdata == 32'h0)
    else $error("mode word readable");
  unmapped_err_a: assert property (pready && (paddr > OFS_OUT_CNT || paddr[1:0] != 2'b00)
    |-> pslverr) else $error("bad address not refused");
  pulse_single_a: assert property (drive_pulse |=> !drive_pulse) else $error("pulse too long");
  pulse_busy_a: assert property (drive_pulse |-> drive_busy) else $error("pulse while idle");
  dir_hold_a: assert property (drive_busy && $past(drive_busy) |-> $stable(drive_dir))
    else $error("direction changed in drive");
  halt_stop_a: assert property (pready && pwrite && paddr == OFS_COMMAND
    && pwdata[3:0] == CMD_HALT |-> ##[1:8] !drive_busy) else $error("halt ignored");
endmodule // spg_scurve_checker
bind spg_scurve_top spg_scurve_checker chk (.sys_clk(sys_clk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .external_stop_inputs(external_stop_inputs),
  .drive_pulse(drive_pulse), .drive_dir(drive_dir), .drive_busy(drive_busy));

// File: tb/scurve_speed_profile_generator_test.sv
`timescale 1ns/10ps
module scurve_speed_profile_generator_test;
  import spg_pkg::*;
  logic        sys_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic        pulse, dir, busy, clr, m_dir, e, b;
  logic [7:0]  paddr, seen;
  logic [3:0]  stop_pins;
  logic [15:0] m_cnt;
  logic [31:0] pwdata, prdata, m_gmin, m_gmax, q, d;
  int          err_total, checks, k, fd;
  spg_scurve_top uut (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_stop_inputs(stop_pins), .drive_pulse(pulse),
    .drive_dir(dir), .drive_busy(busy));
  spg_motor_model drv (.sys_clk(sys_clk), .reset(reset), .clr(clr), .drive_pulse(pulse),
    .drive_dir(dir), .pulse_cnt(m_cnt), .last_dir(m_dir), .gap_min(m_gmin), .gap_max(m_gmax));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rst_val(input int i);
    case (i)
      3, 4: return 32'd8000;
      1, 2, 5, 6: return 32'h1;
      default: return 32'h0;
    endcase
  endfunction
  // Step period in clocks; the truncated phase step makes real steps up to ~1% slower
  function automatic int period(input int sp);
    return 50000000 / sp;
  endfunction
  function automatic int turn_lim(input int n);
    return n / 12 + 2;
  endfunction
  task automatic ck(input logic [31:0] seen_v, input logic [31:0] exp, input string nm);
    checks++;
    if (seen_v !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen_v);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rq, output logic re);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      ck(32'h0, 32'h1, "apb wait");
      test_done();
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rq;
    logic re;
    apb(1'b1, a, wd, rq, re);
  endtask
  // Starts a drive and polls status and step count until it ends
  task automatic drive(input logic [31:0] cmd, input int dp, input int stop_at, input int how);
    logic [31:0] s, c;
    logic [2:0]  prev;
    int i;
    seen = 8'h0;
    fd = 9999;
    prev = 3'h0;
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    wr(OFS_COMMAND, cmd);
    for (i = 0; i < 5000; i++) begin
      apb(1'b0, OFS_STATUS, 32'h0, s, e);
      apb(1'b0, OFS_OUT_CNT, 32'h0, c, e);
      seen[s[4:2]] = 1'b1;
      if (s[4:2] == 3'd2 && fd == 9999) fd = c;
      if (stop_at >= 0 && prev == 3'd1) ck(s[4:2] < 3'd4, 1'b1, "ease before slowing");
      if (dp > 0 && s[4:2] >= 3'd4) ck(c >= dp, 1'b1, "slowdown point");
      prev = s[4:2];
      if (i == stop_at && how == 0) stop_pins <= 4'(($urandom % 15) + 1);
      if (i == stop_at && how != 0) wr(OFS_COMMAND, {28'h0, how == 1 ? CMD_SLOWSTOP : CMD_HALT});
      if (s[0] !== 1'b1) break;
    end
    if (i >= 5000) begin
      ck(32'h0, 32'h1, "drive end");
      test_done();
    end
    stop_pins <= 4'h0;
    repeat (4) @(posedge sys_clk);
  endtask
  initial begin
    {psel, penable, pwrite, clr} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    stop_pins = 4'h0;
    reset = 1'b1;
    err_total = 0;
    checks = 0;
    void'($urandom(32'h9df0a9d7));
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    for (k = 0; k < 13; k++) begin
      if (k != 9 && k != 11) begin
        apb(1'b0, 8'(4 * k), 32'h0, q, e);
        ck(q, rst_val(k), "reset value");
      end
    end
    for (k = 1; k < 7; k++) begin
      d = $urandom;
      wr(8'(4 * k), d);
      apb(1'b0, 8'(4 * k), 32'h0, q, e);
      ck(q, {16'h0, d[15:0]}, "readback");
    end
    wr(OFS_MODE, $urandom);
    apb(1'b0, OFS_MODE, 32'h0, q, e);
    ck(q, 32'h0, "mode read");
    apb(1'b1, 8'h34, 32'h5a5a, q, e);
    ck(e, 1'b1, "unmapped write");
    apb(1'b0, 8'h06, 32'h0, q, e);
    ck({e, q}, {1'b1, 32'h0}, "unaligned read");
    $display("Test registers done");
    wr(OFS_MODE, 32'h4);
    wr(OFS_JERK, 32'd1000 + ($urandom % 1000));
    wr(OFS_ACC_LIM, 32'd8000);
    wr(OFS_START_SP, 32'd60000);
    wr(OFS_DRIVE_SP, 32'd65000);
    wr(OFS_PULSES, 32'd30);
    wr(OFS_SLOW_PT, 32'h0);
    b = 1'($urandom);
    drive({27'h0, b, CMD_FIXED}, 0, -1, 0);
    ck(m_cnt, 30, "step count");
    ck(m_dir, b, "direction");
    ck(seen[1], 1'b1, "rise seen");
    ck(fd <= turn_lim(30), 1'b1, "turn at twelfth");
    ck(seen[4] | seen[5], 1'b1, "auto slowdown");
    ck(m_gmin >= period(65000), 1'b1, "top speed");
    ck(m_gmax <= period(60000) * 102 / 100, 1'b1, "floor speed");
    $display("Test symmetric fixed done");
    // Stop by pin, by slow stop and by halt, each while still rising
    for (k = 0; k < 3; k++) begin
      wr(OFS_DRIVE_SP, 32'd62000);
      drive({27'h0, 1'b0, CMD_CONT}, 0, 120 + ($urandom % 60), k);
      if (k < 2) ck(seen[4] | seen[5], 1'b1, "slow stop");
      ck(m_gmax <= period(60000) * 102 / 100, 1'b1, "stop floor");
      ck(m_cnt > 0, 1'b1, "steps out");
    end
    $display("Test stops done");
    wr(OFS_MODE, 32'h7);
    wr(OFS_SLOWRATE, 32'd500 + ($urandom % 500));
    wr(OFS_DEC_LIM, 32'd8000);
    wr(OFS_DRIVE_SP, 32'd65000);
    wr(OFS_SLOW_PT, 32'd20);
    drive({27'h0, 1'b1, CMD_FIXED}, 20, -1, 0);
    ck(m_cnt, 30, "manual count");
    ck(fd > turn_lim(30), 1'b1, "no twelfth");
    ck(seen[4] | seen[5], 1'b1, "own slowdown");
    $display("Test non-symmetric done");
    test_done();
  end
endmodule // scurve_speed_profile_generator_test
